// >>> bench/asd_host_model.sv
// serial host model: frames command bytes and reads back results
`timescale 1ns/1ps
module asd_host_model (
  output logic      cs_n_pin,  // chip select, idle high
  output logic      sclk_pin,  // serial clock, still outside frames
  output logic      din_pin,   // command data, msb first
  input  wire logic dout_pin   // result data from the device
);
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b1;
    din_pin = 1'b1;
  end
  task automatic frame(input logic [15:0] d, input int n,
                       output logic [15:0] o);
    o = 16'h0000;
    #3; // keep pin changes off the sampling edges
    cs_n_pin = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      din_pin = d[i];
      #80;
      o[i] = dout_pin;
      sclk_pin = 1'b0;
      #80;
      sclk_pin = 1'b1;
    end
    #200;
    cs_n_pin = 1'b1;
    // released line must not keep showing the last bit
    din_pin = ~din_pin;
    #400;
  endtask
endmodule

// >>> bench/asd_top_sva.sv
// checker for the scan and setup command decoder, bound to its top
`timescale 1ns/1ps
module asd_top_sva (
  input wire logic       clk_sys, sys_rst, clk_en, cs_n_pin, dout_pin,
  input wire logic       force_ref_on_bit, dac_powered_any, dac_pullup_any,
  input wire logic       conv_valid, conv_ready, conv_temp,
  input wire logic [3:0] conv_chan,
  input wire logic       adc_ref_internal, adc_ref_ext_single,
  input wire logic       adc_ref_ext_diff, dac_ref_external,
  input wire logic       shared_pin_is_ref, adc_ref_on,
  input wire logic       osc_enable, sclk_timed,
  input wire logic [1:0] clock_mode, ref_mode_field
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // reference routing
  // ----------------------------------------
  property p_ref_int;
    ref_mode_field == 2'h0 |-> adc_ref_internal && !dac_ref_external;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("mode 0 routing");
  property p_ref_dac;
    ref_mode_field == 2'h2 |-> adc_ref_internal && dac_ref_external;
  endproperty
  a_ref_dac: assert property (p_ref_dac) else $error("mode 2 routing");
  property p_ref_ext;
    ref_mode_field == 2'h1 |-> adc_ref_ext_single && dac_ref_external;
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("mode 1 routing");
  property p_ref_diff;
    ref_mode_field == 2'h3 |-> adc_ref_ext_diff && !adc_ref_internal;
  endproperty
  a_ref_diff: assert property (p_ref_diff) else $error("mode 3 routing");
  property p_shared;
    shared_pin_is_ref == ref_mode_field[0];
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin role");
  // inputs may be registered first, so only judge settled levels
  property p_ref_on;
    !$past(sys_rst) && $stable(force_ref_on_bit) && $stable(dac_powered_any)
      && $stable(dac_pullup_any) && $stable(ref_mode_field) |->
      adc_ref_on == (force_ref_on_bit || (ref_mode_field == 2'h0 &&
      (dac_powered_any || dac_pullup_any)));
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference hold");
  // ----------------------------------------
  // clocking, start and conversion requests
  // ----------------------------------------
  property p_osc;
    osc_enable == (clock_mode != 2'h3) && sclk_timed == (clock_mode == 2'h3);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable");
  property p_rst;
    $fell(sys_rst) |-> clock_mode == 2'h2 && ref_mode_field == 2'h2;
  endproperty
  a_rst: assert property (p_rst) else $error("setup reset value");
  property p_skip;
    conv_valid && !conv_temp |-> !(conv_chan == 4'hf && !clock_mode[1])
      && !(conv_chan == 4'he && ref_mode_field[0]);
  endproperty
  a_skip: assert property (p_skip) else $error("reserved pin converted");
  sequence s_stall;
    conv_valid && !conv_ready && clk_en;
  endsequence
  property p_hold;
    s_stall |=> conv_valid && $stable(conv_chan) && $stable(conv_temp);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_dout;
    cs_n_pin [*5] |-> !dout_pin;
  endproperty
  a_dout: assert property (p_dout) else $error("dout idle not zero");
endmodule
bind asd_top asd_top_sva u_sva (.*);

// >>> bench/asd_top_tb.sv
// self-checking bench for the scan and setup command decoder
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module asd_top_tb;
  import asd_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, conv_ready = 1'b0;
  logic conversion_start_pin = 1'b1, temp_done = 1'b0, fifo_valid = 1'b0;
  logic force_ref_on_bit = 1'b0, dac_powered_any = 1'b0;
  logic dac_pullup_any = 1'b0, repeat_count_bit1 = 1'b0;
  logic repeat_count_bit0 = 1'b1;
  logic [11:0] temp_code = 12'h000;
  logic [15:0] fifo_word = 16'h0000, rd;
  logic cs_n_pin, sclk_pin, din_pin, dout_pin, conv_valid, conv_temp;
  logic conv_diff, conv_bipolar, scan_busy, fifo_pop, adc_ref_internal;
  logic adc_ref_ext_single, adc_ref_ext_diff, dac_ref_external;
  logic shared_pin_is_ref, adc_ref_on, osc_enable, sclk_timed, sclk_tick;
  logic [3:0] conv_chan;
  logic [1:0] clock_mode, ref_mode_field;
  logic [7:0] unipolar_map, bipolar_map;
  logic [31:0] st = 32'h000136c1, rv;
  logic [5:0] q[$], e;
  int errors = 0, comparisons = 0;
  int pops = 0, ticks = 0;
  asd_top dut (.*);
  asd_host_model host (.*);
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200_000;
    errors++;
    end_of_test();
  end
  // ----------------------------------------
  // random converter stalls and reference inputs
  // ----------------------------------------
  always @(posedge clk_sys) begin
    rv = xs();
    conv_ready <= rv[0];
    // freeze only while a scan runs, so serial frames keep their timing
    clk_en <= !scan_busy || rv[9:7] != 3'h0;
    if (rv[3:1] == 3'h0)
      {force_ref_on_bit, dac_powered_any, dac_pullup_any} <= rv[6:4];
  end
  // oldest note against each accepted request
  always @(posedge clk_sys) begin
    if (!sys_rst && clk_en && conv_valid && conv_ready) begin
      e = (q.size() > 0) ? q.pop_front() : 6'h3f;
      `CHK({conv_temp, conv_temp ? 5'h00 : {conv_diff, conv_chan}}, e)
      // pairs 4 and 5 (pins 8 to 11) are the bipolar ones set below
      if (!e[5]) `CHK(conv_bipolar, e[4] && e[3:2] == 2'h2)
    end
  end
  always @(posedge clk_sys) begin
    if (clk_en && fifo_pop) pops++;
    if (clk_en && sclk_tick) ticks++;
  end
  task automatic setup(input logic [7:0] b, input logic [1:0] cm, rm);
    host.frame({8'h00, b}, 8, rd);
    `CHK({clock_mode, ref_mode_field}, {cm, rm})
  endtask
  task automatic scan(input logic [7:0] cmd, input logic pin,
                      input logic [5:0] ex[$]);
    q = ex;
    host.frame({8'h00, cmd}, 8, rd);
    if (pin) begin
      `CHK(scan_busy, 1'b0)
      `CHK(q.size(), ex.size())
      @(posedge clk_sys) conversion_start_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      conversion_start_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
    end
    for (int i = 0; i < 3000 && scan_busy !== 1'b0; i++) @(posedge clk_sys);
    `CHK(scan_busy, 1'b0)
    `CHK(q.size(), 0)
  endtask
  task automatic temp_pulse(input logic [11:0] c);
    @(posedge clk_sys);
    temp_done <= 1'b1;
    temp_code <= c;
    @(posedge clk_sys);
    temp_done <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK({clock_mode, ref_mode_field, unipolar_map, bipolar_map}, 20'ha0000)
    for (int m = 0; m < 4; m++) setup({4'h7, m[1:0], 2'h0}, 2'h3, m[1:0]);
    setup(8'h30, 2'h3, 2'h3);
    `CHK(ticks, 32)
    host.frame(16'h620c, 16, rd);
    `CHK(unipolar_map, 8'h0c)
    host.frame(16'h6330, 16, rd);
    `CHK(bipolar_map, 8'h30)
    scan(8'haf, 1'b0, '{6'h20, 6'h14});
    scan(8'h90, 1'b0, '{6'h00, 6'h01, 6'h02});
    scan(8'hea, 1'b0, '{6'h0d, 6'h0e, 6'h0f});
    scan(8'h9c, 1'b0, '{8{6'h03}});
    scan(8'hce, 1'b0, '{6'h18});
    setup(8'h44, 2'h0, 2'h1);
    scan(8'hea, 1'b1, '{6'h0d});
    host.frame(16'h0000, 16, rd);
    `CHK(rd, 16'h0000)
    temp_pulse(12'h5a1);
    temp_pulse(12'hf38);
    host.frame(16'h0000, 16, rd);
    `CHK(rd, 16'h0f38)
    @(posedge clk_sys);
    fifo_valid <= 1'b1;
    fifo_word <= 16'(xs());
    host.frame(16'h0000, 16, rd);
    `CHK(rd, fifo_word)
    `CHK(pops, 1)
    @(posedge clk_sys) fifo_valid <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK({clock_mode, ref_mode_field}, 4'ha)
    `CHK({unipolar_map, bipolar_map}, 16'h0000)
    end_of_test();
  end
endmodule

// >>> rtl/asd_scan_seq.sv
// scan sequencer: walks the channel list and issues conversion requests
`timescale 1ns/1ps
`include "asd_defs.svh"
module asd_scan_seq
  import asd_pkg::*;
(
  input wire logic clk_sys,  // system clock
  input wire logic sys_rst,  // synchronous reset
  input wire logic clk_en,   // freezes all state while low
  asd_scan_if.seq  scan      // configuration and conversion handshake
);
  asd_seq_state_type state, next_state;
  logic [3:0]        cur, next_cur;
  logic [3:0]        last, next_last;
  logic [4:0]        remain, next_remain;
  asd_sweep_type     sweep, next_sweep;
  logic              cur_diff;
  logic [3:0]        lo_pin;
  logic [3:0]        hi_pin;
  logic              skip;
  logic              at_end;

  function automatic logic reserved(input logic [3:0] p);
    reserved = (p == `ASD_CONVERSION_START_PIN_CH && !scan.clk_mode[1]) ||
               (p == `ASD_SECONDARY_REF_PIN_CH && scan.ref_mode[0]);
  endfunction

  always_comb begin
    cur_diff = scan.diff_mask[cur[3:1]];
    lo_pin   = cur_diff ? {cur[3:1], 1'b0} : cur;
    hi_pin   = cur_diff ? {cur[3:1], 1'b1} : cur;
    skip     = reserved(lo_pin) || reserved(hi_pin);
    at_end   = (sweep == ASD_SWEEP_ONCE) ||
               ((sweep == ASD_SWEEP_REPEAT) && remain <= 5'h1) ||
               ((sweep[1] == 1'b0) && hi_pin >= last);
    next_state  = state;
    next_cur    = cur;
    next_last   = last;
    next_remain = remain;
    next_sweep  = sweep;
    case (state)
      SEQ_IDLE: begin
        if (scan.start) begin
          next_sweep = scan.sweep;
          next_cur   = (scan.sweep == ASD_SWEEP_UP_TO) ? 4'h0 : scan.chan;
          next_last  = (scan.sweep == ASD_SWEEP_FROM) ? 4'hf : scan.chan;
          // repeat count: four results per code step
          next_remain = {3'({1'b0, scan.repeat_code} + 3'h1), 2'h0};
          next_state  = scan.temp_req ? SEQ_TEMP : SEQ_CHAN;
        end
      end
      SEQ_TEMP: begin
        if (scan.conv_ready) begin
          next_state = SEQ_CHAN;
        end
      end
      SEQ_CHAN: begin
        if (skip || scan.conv_ready) begin
          next_state = SEQ_NEXT;
        end
      end
      SEQ_NEXT: begin
        if (at_end) begin
          next_state = SEQ_IDLE;
        end else begin
          next_state = SEQ_CHAN;
          if (sweep == ASD_SWEEP_REPEAT) begin
            next_remain = remain - 5'h1;
          end else begin
            next_cur = hi_pin + 4'h1;
          end
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state  <= SEQ_IDLE;
      cur    <= 4'h0;
      last   <= 4'h0;
      remain <= 5'h0;
      sweep  <= ASD_SWEEP_UP_TO;
    end else if (clk_en) begin
      state  <= next_state;
      cur    <= next_cur;
      last   <= next_last;
      remain <= next_remain;
      sweep  <= next_sweep;
    end
  end

  assign scan.busy       = (state != SEQ_IDLE);
  assign scan.conv_valid = (state == SEQ_TEMP) ||
                           ((state == SEQ_CHAN) && !skip);
  assign scan.conv_temp  = (state == SEQ_TEMP);
  assign scan.conv_chan  = lo_pin;
  assign scan.conv_diff  = cur_diff;
endmodule

// >>> rtl/asd_top.sv
// serial command decoder for the converter's scan and setup registers
//
// What this block does
// - reference mode 00: internal reference for both converter and DACs
// - reference mode 10: internal reference for converter, primary pin DACs
// - reference mode 01: primary pin for DACs, secondary pin for converter
// - reference mode 11: differential reference, primary plus, secondary minus
// - shared pin is analog input in modes 00/10, reference in 01/11
// - reference-mode field sits in setup bits 3 and 2
// - converter reference on if forced, or mode 00 with any DAC active
// - scan command bit 0 requests one temperature measurement
// - temperature converts first and is read out first
// - an unread temperature result is replaced by a newer one
// - temperature is two's complement, one eighth degree per step
// - bit 7 set selects scan command: channel, sweep mode, temperature
// - four channel bits are a binary channel number 0 to 15
// - clock modes 1x start on write, modes 0x on start-pin low pulse
// - channels on the start pin (clock modes 0x) or secondary reference pin (reference modes 01/11) are skipped
// - differential pairs ignore the lowest channel bit
// - sweep 00 runs 0 to N, sweep 01 runs N to the top
// - sweep 10 repeats channel N, count from repeat-count bits
// - sweep 11 converts channel N once
// - bits 7..6 equal 01 select the setup command
// - clock mode in setup bits 5 and 4, upper bit resets to one
// - setup bits 1 and 0 pick the next polarity-map register
// - polarity 10 writes unipolar map, 11 writes bipolar map
// - oscillator runs in clock modes 00, 01, 10; mode 11 uses serial clock
// - serial output shifts zeros when no result is buffered
`timescale 1ns/1ps
`include "asd_defs.svh"
module asd_top
  import asd_pkg::*;
(
  input  wire logic        clk_sys,              // system clock, 100 MHz
  input  wire logic        sys_rst,              // synchronous reset
  input  wire logic        clk_en,               // freezes all state
  input  wire logic        cs_n_pin,             // serial chip select
  input  wire logic        sclk_pin,             // serial clock pin
  input  wire logic        din_pin,              // serial data in
  input  wire logic        conversion_start_pin, // start pin, active low
  output logic             dout_pin,             // serial data out
  input  wire logic        force_ref_on_bit,     // forced reference on
  input  wire logic        dac_powered_any,      // some DAC powered up
  input  wire logic        dac_pullup_any,       // some DAC pulled to ref
  input  wire logic        repeat_count_bit1,    // repeat count, upper
  input  wire logic        repeat_count_bit0,    // repeat count, lower
  output logic             conv_valid,           // conversion request
  input  wire logic        conv_ready,           // converter takes request
  output logic [3:0]       conv_chan,            // channel to convert
  output logic             conv_temp,            // request is temperature
  output logic             conv_diff,            // channel is a pair
  output logic             conv_bipolar,         // pair is bipolar
  output logic             scan_busy,            // scan in progress
  input  wire logic        temp_done,            // temperature result ready
  input  wire logic [11:0] temp_code,            // temperature result
  input  wire logic        fifo_valid,           // result buffer not empty
  input  wire logic [15:0] fifo_word,            // oldest buffered result
  output logic             fifo_pop,             // take oldest result
  output logic             adc_ref_internal,     // converter internal ref
  output logic             adc_ref_ext_single,   // converter on secondary
  output logic             adc_ref_ext_diff,     // converter differential
  output logic             dac_ref_external,     // DACs on primary pin
  output logic             shared_pin_is_ref,    // shared pin is a ref
  output logic             adc_ref_on,           // hold reference on
  output logic             osc_enable,           // internal oscillator on
  output logic             sclk_timed,           // serial clock times conv
  output logic             sclk_tick,            // serial clock fall pulse
  output logic [1:0]       clock_mode,           // current clock mode
  output logic [1:0]       ref_mode_field,       // current reference mode
  output logic [7:0]       unipolar_map,         // unipolar-mode register
  output logic [7:0]       bipolar_map           // bipolar-mode register
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       cs_prev;
  logic       sclk_prev;
  logic       start_prev;
  logic       cs_s;
  logic       sclk_s;
  logic       din_s;
  logic       start_s;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_a     <= 4'hf;
      sync_b     <= 4'hf;
      cs_prev    <= 1'b1;
      sclk_prev  <= 1'b1;
      start_prev <= 1'b1;
    end else if (clk_en) begin
      sync_a     <= {cs_n_pin, sclk_pin, din_pin, conversion_start_pin};
      sync_b     <= sync_a;
      cs_prev    <= cs_s;
      sclk_prev  <= sclk_s;
      start_prev <= start_s;
    end
  end

  assign cs_s    = sync_b[3];
  assign sclk_s  = sync_b[2];
  assign din_s   = sync_b[1];
  assign start_s = sync_b[0];

  logic cs_fall;
  logic sclk_fall;
  logic start_rise;
  logic byte_done;

  assign cs_fall    = cs_prev && !cs_s;
  // only edges inside a frame count; the clock may idle either way
  assign sclk_fall  = sclk_prev && !sclk_s && !cs_s;
  // a start pulse is taken at its trailing edge
  assign start_rise = !start_prev && start_s;

  // --------------------------------------------------------------
  // command receiver and register file
  // --------------------------------------------------------------
  asd_rx_state_type rx_state, next_rx_state;
  logic [2:0]       bit_cnt, next_bit_cnt;
  logic [6:0]       shift_in, next_shift_in;
  logic [7:0]       scan_command, next_scan_command;
  logic [1:0]       next_clock_mode;
  logic [1:0]       next_ref_mode;
  logic [1:0]       pol_sel, next_pol_sel;
  logic [7:0]       next_unipolar;
  logic [7:0]       next_bipolar;
  logic             scan_start, next_scan_start;
  logic [7:0]       rx_byte;

  assign rx_byte   = {shift_in, din_s};
  assign byte_done = sclk_fall && (bit_cnt == `ASD_LAST_BIT);

  always_comb begin
    next_rx_state     = rx_state;
    next_bit_cnt      = bit_cnt;
    next_shift_in     = shift_in;
    next_scan_command = scan_command;
    next_clock_mode   = clock_mode;
    next_ref_mode     = ref_mode_field;
    next_pol_sel      = pol_sel;
    next_unipolar     = unipolar_map;
    next_bipolar      = bipolar_map;
    next_scan_start   = 1'b0;
    if (cs_fall) begin
      next_rx_state = RX_CMD;
      next_bit_cnt  = 3'h0;
    end else if (sclk_fall) begin
      next_shift_in = rx_byte[6:0];
      next_bit_cnt  = bit_cnt + 3'h1;
    end
    if (byte_done) begin
      case (rx_state)
        RX_CMD: begin
          next_rx_state = RX_SKIP;
          if (rx_byte[`ASD_CMD_CONV_BIT]) begin
            next_scan_command = rx_byte;
            next_scan_start   = clock_mode[1];
          end else if (rx_byte[`ASD_CMD_SETUP_BIT]) begin
            next_clock_mode = rx_byte[`ASD_CLK_MSB:`ASD_CLK_LSB];
            next_ref_mode   = rx_byte[`ASD_REF_MSB:`ASD_REF_LSB];
            next_pol_sel    = rx_byte[`ASD_POL_MSB:`ASD_POL_LSB];
            if (rx_byte[`ASD_POL_MSB]) begin
              next_rx_state = RX_POLARITY;
            end
          end
        end
        RX_POLARITY: begin
          next_rx_state = RX_SKIP;
          if (pol_sel[0]) begin
            next_bipolar = rx_byte;
          end else begin
            next_unipolar = rx_byte;
          end
        end
        RX_SKIP: next_rx_state = RX_SKIP;
        default: next_rx_state = RX_SKIP;
      endcase
    end
    if (start_rise && !clock_mode[1]) begin
      next_scan_start = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_state       <= RX_SKIP;
      bit_cnt        <= 3'h0;
      shift_in       <= 7'h00;
      scan_command   <= `ASD_CMD_RESET;
      clock_mode     <= `ASD_CLK_RESET;
      ref_mode_field <= `ASD_REF_RESET;
      pol_sel        <= `ASD_POL_RESET;
      unipolar_map   <= `ASD_MAP_RESET;
      bipolar_map    <= `ASD_MAP_RESET;
      scan_start     <= 1'b0;
    end else if (clk_en) begin
      rx_state       <= next_rx_state;
      bit_cnt        <= next_bit_cnt;
      shift_in       <= next_shift_in;
      scan_command   <= next_scan_command;
      clock_mode     <= next_clock_mode;
      ref_mode_field <= next_ref_mode;
      pol_sel        <= next_pol_sel;
      unipolar_map   <= next_unipolar;
      bipolar_map    <= next_bipolar;
      scan_start     <= next_scan_start;
    end
  end

  // --------------------------------------------------------------
  // result readout
  // --------------------------------------------------------------
  logic [15:0] tx_shift, next_tx_shift;
  logic [11:0] temp_word, next_temp_word;
  logic        temp_pending, next_temp_pending;

  assign fifo_pop = cs_fall && !temp_pending && fifo_valid && clk_en;

  always_comb begin
    next_tx_shift     = tx_shift;
    next_temp_word    = temp_word;
    next_temp_pending = temp_pending;
    if (cs_fall) begin
      if (temp_pending) begin
        next_tx_shift     = {4'h0, temp_word};
        next_temp_pending = 1'b0;
      end else if (fifo_valid) begin
        next_tx_shift = fifo_word;
      end else begin
        next_tx_shift = 16'h0000;
      end
    end else if (sclk_fall) begin
      // zeros follow once the word is out
      next_tx_shift = {tx_shift[14:0], 1'b0};
    end
    // a result arriving with the readout still counts
    if (temp_done) begin
      next_temp_word    = temp_code;
      next_temp_pending = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_shift     <= 16'h0000;
      temp_word    <= 12'h000;
      temp_pending <= 1'b0;
      dout_pin     <= 1'b0;
    end else if (clk_en) begin
      tx_shift     <= next_tx_shift;
      temp_word    <= next_temp_word;
      temp_pending <= next_temp_pending;
      dout_pin     <= next_tx_shift[15] && !cs_s;
    end
  end

  // --------------------------------------------------------------
  // reference and clock routing
  // --------------------------------------------------------------
  assign adc_ref_internal   = (ref_mode_field == ASD_REF_INT) ||
                              (ref_mode_field == ASD_REF_INT_DACEXT);
  assign dac_ref_external   = (ref_mode_field != ASD_REF_INT);
  assign adc_ref_ext_single = (ref_mode_field == ASD_REF_EXT_SINGLE);
  assign adc_ref_ext_diff   = (ref_mode_field == ASD_REF_EXT_DIFF);
  assign shared_pin_is_ref  = ref_mode_field[0];
  assign adc_ref_on = force_ref_on_bit ||
                      ((ref_mode_field == ASD_REF_INT) &&
                       (dac_powered_any || dac_pullup_any));
  assign osc_enable = (clock_mode != 2'h3);
  assign sclk_timed = (clock_mode == 2'h3);
  assign sclk_tick  = sclk_fall && sclk_timed;

  // --------------------------------------------------------------
  // scan sequencer
  // --------------------------------------------------------------
  asd_scan_if scan_bus ();

  assign scan_bus.start       = scan_start;
  assign scan_bus.chan        = scan_command[`ASD_CHAN_MSB:`ASD_CHAN_LSB];
  assign scan_bus.sweep       =
    asd_sweep_type'(scan_command[`ASD_SWEEP_MSB:`ASD_SWEEP_LSB]);
  assign scan_bus.temp_req    = scan_command[`ASD_TEMP_BIT];
  assign scan_bus.clk_mode    = clock_mode;
  assign scan_bus.ref_mode    = ref_mode_field;
  assign scan_bus.diff_mask   = unipolar_map | bipolar_map;
  assign scan_bus.repeat_code = {repeat_count_bit1, repeat_count_bit0};
  assign scan_bus.conv_ready  = conv_ready;

  asd_scan_seq u_seq (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .scan    (scan_bus)
  );

  assign conv_valid   = scan_bus.conv_valid;
  assign conv_chan    = scan_bus.conv_chan;
  assign conv_temp    = scan_bus.conv_temp;
  assign conv_diff    = scan_bus.conv_diff;
  assign conv_bipolar = scan_bus.conv_diff && bipolar_map[conv_chan[3:1]];
  assign scan_busy    = scan_bus.busy;
endmodule

// >>> shared/asd_defs.svh
// command byte field positions, reset values and fixed channel numbers
`ifndef ASD_DEFS_SVH
`define ASD_DEFS_SVH
`define ASD_CMD_CONV_BIT   7
`define ASD_CMD_SETUP_BIT  6
`define ASD_CHAN_MSB       6
`define ASD_CHAN_LSB       3
`define ASD_SWEEP_MSB      2
`define ASD_SWEEP_LSB      1
`define ASD_TEMP_BIT       0
`define ASD_CLK_MSB        5
`define ASD_CLK_LSB        4
`define ASD_REF_MSB        3
`define ASD_REF_LSB        2
`define ASD_POL_MSB        1
`define ASD_POL_LSB        0
`define ASD_CLK_RESET      2'h2
`define ASD_REF_RESET      2'h2
`define ASD_POL_RESET      2'h0
`define ASD_MAP_RESET      8'h00
`define ASD_CMD_RESET      8'h00
`define ASD_CONVERSION_START_PIN_CH       4'hf
`define ASD_SECONDARY_REF_PIN_CH        4'he
`define ASD_LAST_BIT       3'h7
`endif

// >>> shared/asd_pkg.sv
// types shared by the scan/setup decoder modules
package asd_pkg;
  typedef enum logic [1:0] {
    ASD_SWEEP_UP_TO  = 2'h0,
    ASD_SWEEP_FROM   = 2'h1,
    ASD_SWEEP_REPEAT = 2'h2,
    ASD_SWEEP_ONCE   = 2'h3
  } asd_sweep_type;
  typedef enum logic [1:0] {
    ASD_REF_INT        = 2'h0,
    ASD_REF_EXT_SINGLE = 2'h1,
    ASD_REF_INT_DACEXT = 2'h2,
    ASD_REF_EXT_DIFF   = 2'h3
  } asd_ref_type;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_TEMP = 4'h2,
    SEQ_CHAN = 4'h4,
    SEQ_NEXT = 4'h8
  } asd_seq_state_type;
  typedef enum logic [2:0] {
    RX_CMD      = 3'h1,
    RX_POLARITY = 3'h2,
    RX_SKIP     = 3'h4
  } asd_rx_state_type;
endpackage

// >>> shared/asd_scan_if.sv
// scan configuration and conversion handshake between decoder and sequencer
`timescale 1ns/1ps
interface asd_scan_if;
  import asd_pkg::*;
  logic          start;
  logic [3:0]    chan;
  asd_sweep_type sweep;
  logic          temp_req;
  logic [1:0]    clk_mode;
  logic [1:0]    ref_mode;
  logic [7:0]    diff_mask;
  logic [1:0]    repeat_code;
  logic          busy;
  logic          conv_valid;
  logic          conv_ready;
  logic [3:0]    conv_chan;
  logic          conv_temp;
  logic          conv_diff;
  modport dec (output start, chan, sweep, temp_req, clk_mode, ref_mode,
               output diff_mask, repeat_code, conv_ready,
               input busy, conv_valid, conv_chan, conv_temp, conv_diff);
  modport seq (input start, chan, sweep, temp_req, clk_mode, ref_mode,
               input diff_mask, repeat_code, conv_ready,
               output busy, conv_valid, conv_chan, conv_temp, conv_diff);
endinterface
